// file: design/demod_preamble_detect_ctrl.sv
// Purpose: demodulator configuration, preamble declaration, sfd timeout, rssi and status capture
// Assumes: sample and correlator results arrive on MCLK from in-chip logic
// Notes:   ahb-lite slave with zero wait states, always OKAY

`default_nettype none

module demod_preamble_detect_ctrl import demod_pkg::*; (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // sample stream in and out
  input wire logic SAMPLE_VALID,
  input wire logic [SAMPLE_W-1:0] SAMPLE_I,
  input wire logic [SAMPLE_W-1:0] SAMPLE_Q,
  output logic DEMOD_VALID,
  output logic [SAMPLE_W-1:0] DEMOD_I,
  output logic [SAMPLE_W-1:0] DEMOD_Q,
  output logic OFFSET_VALID,
  output logic [3:0] OFFSET_INDEX,
  output logic [3:0] OFFSET_SHIFT,
  // correlator results
  input wire logic CORR_VALID,
  input wire logic [PEAK_W-1:0] CORR_PEAK,
  input wire logic [PEAK_W-1:0] CORR_BASE,
  input wire logic [5:0] CORR_TIME,
  input wire logic [3:0] CORR_FREQ,
  input wire logic SYMBOL_END,
  // frame and measurement events
  input wire logic SFD_FOUND,
  input wire logic PACKET_END,
  input wire logic MEASURE_END,
  // rssi, gain and antenna
  input wire logic [7:0] RSSI_RAW,
  input wire logic [3:0] BB_MAG,
  input wire logic AGC_FROZEN,
  input wire logic AUTO_ANTENNA,
  // control and result outputs
  output logic TC_QUARTER,
  output logic LIF_UP,
  output logic ANT_AUTO,
  output logic ANTENNA,
  output logic SYM_INDEX_VALID,
  output logic [5:0] SYM_TIME_INDEX,
  output logic [3:0] SYM_FREQ_INDEX,
  output logic PREAMBLE_DETECTED,
  output logic CCA_BUSY,
  output logic [7:0] RSSI_CAL
);

  // ==========================================================
  // registers and fields
  logic [31:0] ctrl_a, ctrl_b, ctrl_c, status;
  logic [31:0] next_ctrl_a, next_ctrl_b, next_ctrl_c;
  logic wr_pend;
  logic [31:0] wr_addr;

  wire [14:0] offset_en = ctrl_a[OFFSET_EN_LSB +: OFFSETS];
  wire rule_strict = ctrl_a[RULE_SEL_BIT];
  wire [3:0] corr_scale = ctrl_b[CORR_SCALE_LSB +: 4];
  wire [3:0] freq_span = ctrl_b[FREQ_SPAN_LSB +: 4];
  wire [5:0] time_span = ctrl_b[TIME_SPAN_LSB +: 6];
  wire [3:0] sfd_timeout = ctrl_b[SFD_TIMEOUT_LSB +: 4];
  wire [5:0] rssi_cal_field = ctrl_c[RSSI_CAL_LSB +: 6];
  wire [7:0] rssi_thr = ctrl_c[RSSI_THR_LSB +: 8];

  // ==========================================================
  // ahb-lite slave
  wire ahb_go = HSEL & HTRANS[1] & HREADY;
  wire [31:0] wdata_masked = HWDATA;
  wire hit_a = wr_pend && (wr_addr == ADDR_CTRL_A);
  wire hit_b = wr_pend && (wr_addr == ADDR_CTRL_B);
  wire hit_c = wr_pend && (wr_addr == ADDR_CTRL_C);

  assign next_ctrl_a = hit_a ? (wdata_masked & CTRL_A_MASK) : ctrl_a;
  assign next_ctrl_b = hit_b ? (wdata_masked & CTRL_B_MASK) : ctrl_b;
  assign next_ctrl_c = hit_c ? (wdata_masked & CTRL_C_MASK) : ctrl_c;

  // reads see a write still in its data phase
  wire [31:0] read_mux =
    (HADDR == ADDR_CTRL_A) ? next_ctrl_a :
    (HADDR == ADDR_CTRL_B) ? next_ctrl_b :
    (HADDR == ADDR_CTRL_C) ? next_ctrl_c :
    (HADDR == ADDR_STATUS) ? status : 32'h00000000;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h00000000;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend <= ahb_go & HWRITE;
      wr_addr <= HADDR;
      if (ahb_go && !HWRITE) begin
        HRDATA <= read_mux;
      end
    end
  end

  // status register has no write path
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_a <= CTRL_A_RESET;
      ctrl_b <= CTRL_B_RESET;
      ctrl_c <= CTRL_C_RESET;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      ctrl_c <= next_ctrl_c;
    end
  end

  // ==========================================================
  // sample input and offset sequencing
  function automatic logic [3:0] next_offset(input logic [14:0] mask, input logic [3:0] cur);
    logic [3:0] pick;
    logic [4:0] c;
    pick = cur;
    c = 5'h00;
    for (int k = OFFSETS; k >= 1; k--) begin
      c = 5'(cur) + 5'(k);
      if (c >= 5'(OFFSETS)) c = c - 5'(OFFSETS);
      if (mask[c[3:0]]) pick = c[3:0];
    end
    return pick;
  endfunction

  wire [3:0] offset_step = next_offset(offset_en, OFFSET_INDEX);

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      DEMOD_VALID <= 1'b0;
      DEMOD_I <= '0;
      DEMOD_Q <= '0;
      OFFSET_VALID <= 1'b0;
      OFFSET_INDEX <= 4'h0;
      OFFSET_SHIFT <= ZERO_OFFSET;
    end else begin
      DEMOD_VALID <= SAMPLE_VALID;
      DEMOD_I <= ctrl_a[IQ_SWAP_BIT] ? SAMPLE_Q : SAMPLE_I;
      DEMOD_Q <= ctrl_a[IQ_SWAP_BIT] ? SAMPLE_I : SAMPLE_Q;
      OFFSET_VALID <= |offset_en;
      if (SAMPLE_VALID) begin
        OFFSET_INDEX <= offset_step;
        OFFSET_SHIFT <= 4'(ZERO_OFFSET - offset_step);
      end
    end
  end

  // ==========================================================
  // largest peak per symbol
  logic have_peak;
  logic [PEAK_W-1:0] best_peak, best_base;
  logic [5:0] best_time;
  logic [3:0] best_freq;

  wire take_new = CORR_VALID && (!have_peak || CORR_PEAK > best_peak);
  wire cur_have = have_peak | CORR_VALID;
  wire [PEAK_W-1:0] cur_peak = take_new ? CORR_PEAK : best_peak;
  wire [PEAK_W-1:0] cur_base = take_new ? CORR_BASE : best_base;
  wire [5:0] cur_time = take_new ? CORR_TIME : best_time;
  wire [3:0] cur_freq = take_new ? CORR_FREQ : best_freq;
  wire [20:0] peak_scaled = {1'b0, cur_peak, 4'h0};
  wire [20:0] thr_scaled = 21'(cur_base) * 21'({1'b1, corr_scale});
  wire sym_ok = cur_have && (peak_scaled > thr_scaled);

  always_ff @(posedge MCLK) begin
    if (RESET || SYMBOL_END) begin
      have_peak <= 1'b0;
      best_peak <= '0;
      best_base <= '0;
      best_time <= 6'h00;
      best_freq <= 4'h0;
    end else if (take_new) begin
      have_peak <= 1'b1;
      best_peak <= CORR_PEAK;
      best_base <= CORR_BASE;
      best_time <= CORR_TIME;
      best_freq <= CORR_FREQ;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      SYM_INDEX_VALID <= 1'b0;
      SYM_TIME_INDEX <= 6'h00;
      SYM_FREQ_INDEX <= 4'h0;
    end else begin
      SYM_INDEX_VALID <= SYMBOL_END & cur_have;
      if (SYMBOL_END) begin
        SYM_TIME_INDEX <= cur_time;
        SYM_FREQ_INDEX <= cur_freq;
      end
    end
  end

  // ==========================================================
  // symbol history and similarity windows
  rx_state_t state;
  logic [HIST-1:0] hist_ok;
  logic [5:0] hist_t [HIST];
  logic [3:0] hist_f [HIST];
  logic [HIST-1:0] win_hit;
  logic hist_clear;

  // window e leaves out entry e; entry 0 is the newest symbol
  for (genvar e = 0; e < HIST; e++) begin : g_win
    logic all_ok;
    logic [5:0] tmin, tmax;
    logic [3:0] fmin, fmax;
    always_comb begin
      all_ok = 1'b1;
      tmin = 6'h3f;
      tmax = 6'h00;
      fmin = 4'hf;
      fmax = 4'h0;
      for (int i = 0; i < HIST; i++) begin
        if (i != e) begin
          all_ok = all_ok & hist_ok[i];
          if (hist_t[i] < tmin) tmin = hist_t[i];
          if (hist_t[i] > tmax) tmax = hist_t[i];
          if (hist_f[i] < fmin) fmin = hist_f[i];
          if (hist_f[i] > fmax) fmax = hist_f[i];
        end
      end
    end
    assign win_hit[e] = all_ok && (4'(fmax - fmin) <= freq_span)
                        && (6'(tmax - tmin) <= time_span);
  end

  // strict rule looks only at the newest four
  wire preamble_hit = rule_strict ? win_hit[HIST-1] : |win_hit;

  always_ff @(posedge MCLK) begin
    if (RESET || hist_clear) begin
      hist_ok <= '0;
      for (int i = 0; i < HIST; i++) begin
        hist_t[i] <= 6'h00;
        hist_f[i] <= 4'h0;
      end
    end else if (SYMBOL_END && state == SEARCH) begin
      hist_ok <= {hist_ok[HIST-2:0], sym_ok};
      hist_t[0] <= cur_time;
      hist_f[0] <= cur_freq;
      for (int i = 1; i < HIST; i++) begin
        hist_t[i] <= hist_t[i-1];
        hist_f[i] <= hist_f[i-1];
      end
    end
  end

  // ==========================================================
  // preamble, sfd search and frame tracking
  logic [3:0] sym_count;
  logic [3:0] freq_corr;
  wire sfd_expired = SYMBOL_END && (5'(sym_count) + 5'h01 >= 5'(sfd_timeout));

  assign hist_clear = (state != SEARCH);

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= SEARCH;
      PREAMBLE_DETECTED <= 1'b0;
      sym_count <= 4'h0;
      freq_corr <= ZERO_OFFSET;
    end else begin
      case (state)
        SEARCH: begin
          sym_count <= 4'h0;
          if (preamble_hit) begin
            state <= SFD_WAIT;
            PREAMBLE_DETECTED <= 1'b1;
            freq_corr <= hist_f[0];
          end
        end
        SFD_WAIT: begin
          if (SFD_FOUND) begin
            state <= FRAME;
          end else if (sfd_expired) begin
            state <= SEARCH;
            PREAMBLE_DETECTED <= 1'b0;
          end else if (SYMBOL_END) begin
            sym_count <= sym_count + 4'h1;
          end
        end
        FRAME: begin
          if (PACKET_END) begin
            state <= SEARCH;
            PREAMBLE_DETECTED <= 1'b0;
          end
        end
        default: state <= SEARCH;
      endcase
    end
  end

  // ==========================================================
  // rssi, cca, antenna and status capture
  wire signed [9:0] rssi_sum = $signed({2'b00, RSSI_RAW}) + $signed({{4{rssi_cal_field[5]}}, rssi_cal_field});
  wire [7:0] rssi_clamped =
    rssi_sum[9] ? 8'h00 :
    (rssi_sum > $signed({2'b00, RSSI_TOP})) ? RSSI_TOP : rssi_sum[7:0];
  logic [3:0] mag_track;

  assign TC_QUARTER = ctrl_a[TC_BIT];
  assign LIF_UP = ctrl_a[LIF_UP_BIT];
  assign ANT_AUTO = ctrl_a[ANT_AUTO_BIT];

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ANTENNA <= 1'b0;
      RSSI_CAL <= 8'h00;
      CCA_BUSY <= 1'b0;
      mag_track <= 4'h0;
      status <= 32'h00000000;
    end else begin
      ANTENNA <= ctrl_a[ANT_AUTO_BIT] ? AUTO_ANTENNA : ctrl_a[ANT_PICK_BIT];
      RSSI_CAL <= rssi_clamped;
      CCA_BUSY <= rssi_clamped > rssi_thr;
      if (!AGC_FROZEN) begin
        mag_track <= BB_MAG;
      end
      if (PACKET_END || MEASURE_END) begin
        status <= 32'h00000000;
        status[ST_MAG_LSB +: 4] <= mag_track;
        status[ST_ANT_BIT] <= ANTENNA;
        status[ST_FREQ_LSB +: 4] <= freq_corr;
        status[ST_RSSI_LSB +: 8] <= rssi_clamped;
      end
    end
  end

endmodule

`default_nettype wire

// file: design/demod_pkg.sv
// Purpose: constants for the demodulator preamble detect and control block
// Assumes: one 50 MHz clock, registers on an ahb-lite slave
// Notes:   all offsets are byte addresses

`default_nettype none

package demod_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] ADDR_CTRL_A = 32'h40014100;
  localparam logic [31:0] ADDR_CTRL_B = 32'h40014104;
  localparam logic [31:0] ADDR_CTRL_C = 32'h40014108;
  localparam logic [31:0] ADDR_STATUS = 32'h4001410c;

  // ==========================================================
  // reset values and writable bits
  localparam logic [31:0] CTRL_A_RESET = 32'h7fff0044;
  localparam logic [31:0] CTRL_B_RESET = 32'h08010308;
  localparam logic [31:0] CTRL_C_RESET = 32'h000000ff;
  localparam logic [31:0] CTRL_A_MASK = 32'h7fff007e;
  localparam logic [31:0] CTRL_B_MASK = 32'h0f0f3f0f;
  localparam logic [31:0] CTRL_C_MASK = 32'h00003fff;

  // ==========================================================
  // field positions
  localparam int OFFSET_EN_LSB = 16;
  localparam int TC_BIT = 6;
  localparam int ANT_PICK_BIT = 5;
  localparam int ANT_AUTO_BIT = 4;
  localparam int RULE_SEL_BIT = 3;
  localparam int LIF_UP_BIT = 2;
  localparam int IQ_SWAP_BIT = 1;
  localparam int CORR_SCALE_LSB = 24;
  localparam int FREQ_SPAN_LSB = 16;
  localparam int TIME_SPAN_LSB = 8;
  localparam int SFD_TIMEOUT_LSB = 0;
  localparam int RSSI_CAL_LSB = 8;
  localparam int RSSI_THR_LSB = 0;
  localparam int ST_MAG_LSB = 16;
  localparam int ST_ANT_BIT = 12;
  localparam int ST_FREQ_LSB = 8;
  localparam int ST_RSSI_LSB = 0;

  // ==========================================================
  // widths and codes
  localparam int OFFSETS = 15;
  localparam int HIST = 5;
  localparam int SAMPLE_W = 12;
  localparam int PEAK_W = 16;
  localparam logic [3:0] ZERO_OFFSET = 4'h7;
  localparam logic [7:0] RSSI_TOP = 8'h7f;

  typedef enum logic [1:0] {SEARCH, SFD_WAIT, FRAME} rx_state_t;

endpackage

`default_nettype wire

// file: verification/demod_ctrl_sva.sv
// Purpose: port checks for demod_preamble_detect_ctrl
// Assumes: one clock, synchronous active-high reset
// Notes: bound into the block after the module
`default_nettype none
module demod_ctrl_sva import demod_pkg::*; (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // sample stream
  input wire logic SAMPLE_VALID,
  input wire logic [SAMPLE_W-1:0] SAMPLE_I,
  input wire logic [SAMPLE_W-1:0] SAMPLE_Q,
  input wire logic DEMOD_VALID,
  input wire logic [SAMPLE_W-1:0] DEMOD_I,
  input wire logic [SAMPLE_W-1:0] DEMOD_Q,
  input wire logic [3:0] OFFSET_INDEX,
  input wire logic [3:0] OFFSET_SHIFT,
  // detection
  input wire logic CORR_VALID,
  input wire logic SYMBOL_END,
  input wire logic PACKET_END,
  input wire logic SYM_INDEX_VALID,
  input wire logic PREAMBLE_DETECTED,
  // rssi and antenna
  input wire logic [7:0] RSSI_CAL,
  input wire logic ANT_AUTO,
  input wire logic ANTENNA,
  input wire logic AUTO_ANTENNA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ==========
  // sequences
  sequence sym_closed;
    SYMBOL_END && CORR_VALID;
  endsequence
  sequence pushed_before;
    $past(SYMBOL_END, 2);
  endsequence
  // ==========
  // assertions
  iq_path_a:
    assert property (DEMOD_VALID |-> $past(SAMPLE_VALID) && (DEMOD_I == $past(SAMPLE_I) && DEMOD_Q == $past(SAMPLE_Q)
      || DEMOD_I == $past(SAMPLE_Q) && DEMOD_Q == $past(SAMPLE_I))) else $error("demod sample not from input");
  shift_opp_a:
    assert property (OFFSET_SHIFT == 4'h7 - OFFSET_INDEX) else $error("shift not opposite of offset");
  index_range_a:
    assert property (OFFSET_INDEX <= 4'he) else $error("offset index out of range");
  rssi_clamp_a:
    assert property (RSSI_CAL <= 8'h7f) else $error("rssi above top code");
  sym_result_a:
    assert property (sym_closed |=> SYM_INDEX_VALID) else $error("no symbol result");
  detect_cause_a:
    assert property ($rose(PREAMBLE_DETECTED) |-> pushed_before) else $error("preamble without symbol");
  detect_drop_a:
    assert property ($fell(PREAMBLE_DETECTED) |-> $past(SYMBOL_END) || $past(SYMBOL_END, 2) || $past(PACKET_END)
      || $past(PACKET_END, 2)) else $error("preamble dropped without cause");
  ant_follow_a:
    assert property (ANT_AUTO && $past(ANT_AUTO) |-> ANTENNA == $past(AUTO_ANTENNA)) else $error("antenna not auto");
endmodule
bind demod_preamble_detect_ctrl demod_ctrl_sva u_sva (
  .MCLK(MCLK), .RESET(RESET), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_I(SAMPLE_I), .SAMPLE_Q(SAMPLE_Q),
  .DEMOD_VALID(DEMOD_VALID), .DEMOD_I(DEMOD_I), .DEMOD_Q(DEMOD_Q), .OFFSET_INDEX(OFFSET_INDEX),
  .OFFSET_SHIFT(OFFSET_SHIFT), .CORR_VALID(CORR_VALID), .SYMBOL_END(SYMBOL_END), .PACKET_END(PACKET_END),
  .SYM_INDEX_VALID(SYM_INDEX_VALID), .PREAMBLE_DETECTED(PREAMBLE_DETECTED), .RSSI_CAL(RSSI_CAL),
  .ANT_AUTO(ANT_AUTO), .ANTENNA(ANTENNA), .AUTO_ANTENNA(AUTO_ANTENNA)
);
`default_nettype wire

// file: verification/demod_rx_source.sv
// Purpose: receive path model feeding baseband samples
// Assumes: samples every two cycles, or every eight when slow
// Notes: data lines change every cycle, valid or not
`default_nettype none
module demod_rx_source import demod_pkg::*; (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  // sample stream
  output logic valid,
  output logic [SAMPLE_W-1:0] i,
  output logic [SAMPLE_W-1:0] q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SAMPLE_W-1:0] cnt;
  always_ff @(posedge clk) begin
    cnt <= rst ? '0 : cnt + 1'b1;
    valid <= !rst && (slow ? cnt[2:0] == 3'h7 : cnt[0]);
  end
  assign i = cnt;
  assign q = cnt ^ 12'ha5c;
endmodule
`default_nettype wire

// file: verification/tb_demod_preamble_detect_ctrl.sv
// Purpose: self-checking bench for demod_preamble_detect_ctrl
// Assumes: 50 MHz clock, ahb-lite single word transfers
// Notes: correlator results and events are driven by hand
`default_nettype none
module tb_demod_preamble_detect_ctrl import demod_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP, slow = 0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd_val;
  wire logic HREADY = HREADYOUT;
  logic SAMPLE_VALID, DEMOD_VALID, OFFSET_VALID, SYM_INDEX_VALID, PREAMBLE_DETECTED, CCA_BUSY;
  logic [SAMPLE_W-1:0] SAMPLE_I, SAMPLE_Q, DEMOD_I, DEMOD_Q;
  logic [3:0] OFFSET_INDEX, OFFSET_SHIFT, SYM_FREQ_INDEX, CORR_FREQ = 4'h7, BB_MAG = 4'h0;
  logic [5:0] SYM_TIME_INDEX, CORR_TIME = 6'h0;
  logic [PEAK_W-1:0] CORR_PEAK = 16'h0, CORR_BASE = 16'd100;
  logic CORR_VALID = 0, SYMBOL_END = 0, AGC_FROZEN = 0, AUTO_ANTENNA = 0;
  logic TC_QUARTER, LIF_UP, ANT_AUTO, ANTENNA;
  logic [7:0] RSSI_RAW = 8'h0, RSSI_CAL;
  logic [2:0] ev = 3'h0;
  wire logic SFD_FOUND = ev[0];
  wire logic PACKET_END = ev[1];
  wire logic MEASURE_END = ev[2];
  int err_count = 0, n_tests = 0, cyc = 0;
  demod_preamble_detect_ctrl DUT (
    .MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_I(SAMPLE_I), .SAMPLE_Q(SAMPLE_Q), .DEMOD_VALID(DEMOD_VALID),
    .DEMOD_I(DEMOD_I), .DEMOD_Q(DEMOD_Q), .OFFSET_VALID(OFFSET_VALID), .OFFSET_INDEX(OFFSET_INDEX),
    .OFFSET_SHIFT(OFFSET_SHIFT), .CORR_VALID(CORR_VALID), .CORR_PEAK(CORR_PEAK), .CORR_BASE(CORR_BASE),
    .CORR_TIME(CORR_TIME), .CORR_FREQ(CORR_FREQ), .SYMBOL_END(SYMBOL_END), .SFD_FOUND(SFD_FOUND),
    .PACKET_END(PACKET_END), .MEASURE_END(MEASURE_END), .RSSI_RAW(RSSI_RAW), .BB_MAG(BB_MAG),
    .AGC_FROZEN(AGC_FROZEN), .AUTO_ANTENNA(AUTO_ANTENNA), .TC_QUARTER(TC_QUARTER), .LIF_UP(LIF_UP),
    .ANT_AUTO(ANT_AUTO), .ANTENNA(ANTENNA), .SYM_INDEX_VALID(SYM_INDEX_VALID), .SYM_TIME_INDEX(SYM_TIME_INDEX),
    .SYM_FREQ_INDEX(SYM_FREQ_INDEX), .PREAMBLE_DETECTED(PREAMBLE_DETECTED), .CCA_BUSY(CCA_BUSY),
    .RSSI_CAL(RSSI_CAL)
  );
  demod_rx_source u_src (.clk(MCLK), .rst(RESET), .slow(slow), .valid(SAMPLE_VALID), .i(SAMPLE_I), .q(SAMPLE_Q));
  always #10 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end
  // ==========
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    rd_val = HRDATA;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge MCLK);
    ev <= m;
    @(posedge MCLK);
    ev <= 3'h0;
  endtask
  task automatic sym(input logic [15:0] pk, input logic [5:0] t, input logic [3:0] f, input logic pd);
    @(posedge MCLK);
    CORR_VALID <= 1'b1;
    SYMBOL_END <= 1'b1;
    CORR_PEAK <= pk;
    CORR_TIME <= t;
    CORR_FREQ <= f;
    @(posedge MCLK);
    CORR_VALID <= 1'b0;
    SYMBOL_END <= 1'b0;
    #1 chk({SYM_INDEX_VALID, SYM_FREQ_INDEX, SYM_TIME_INDEX}, {1'b1, f, t});
    @(posedge MCLK);
    #1 chk(PREAMBLE_DETECTED, pd);
  endtask
  task automatic oks(input int n);
    repeat (n) sym(16'd151, 6'd10, 4'h7, 1'b0);
  endtask
  task automatic rs(input logic [5:0] cal, input logic [7:0] raw, input logic [7:0] e_cal, input logic e_busy);
    wr(ADDR_CTRL_C, {18'h0, cal, 8'h40});
    RSSI_RAW <= raw;
    repeat (2) @(posedge MCLK);
    #1 chk(RSSI_CAL, e_cal);
    chk(CCA_BUSY, e_busy);
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    rd(ADDR_CTRL_A, 32'h7fff0044);
    chk({HREADYOUT, HRESP}, 32'h2);
    rd(ADDR_CTRL_B, 32'h08010308);
    rd(ADDR_CTRL_C, 32'h000000ff);
    wr(ADDR_CTRL_A, 32'hffffffff);
    rd(ADDR_CTRL_A, 32'h7fff007e);
    chk({TC_QUARTER, LIF_UP, ANT_AUTO}, 3'h7);
    wr(ADDR_CTRL_B, 32'hffffffff);
    rd(ADDR_CTRL_B, 32'h0f0f3f0f);
    wr(ADDR_CTRL_C, 32'hffffffff);
    rd(ADDR_CTRL_C, 32'h00003fff);
    wr(ADDR_STATUS, 32'hffffffff);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_STATUS + 32'h4, 32'h1);
    rd(ADDR_STATUS + 32'h4, 32'h0);
    wr(ADDR_CTRL_A, 32'h7fff0000);
    rd(ADDR_CTRL_B, 32'h0f0f3f0f);
    chk({TC_QUARTER, LIF_UP, ANT_AUTO}, 3'h0);
    wr(ADDR_CTRL_B, 32'h08010308);
  endtask
  task automatic t_stream;
    logic [SAMPLE_W-1:0] si;
    logic [3:0] idx;
    wr(ADDR_CTRL_A, 32'h40010046);
    @(posedge MCLK iff SAMPLE_VALID === 1'b1);
    slow <= 1'b1;
    #1 idx = OFFSET_INDEX;
    chk(idx % 4'he, 4'h0);
    for (int k = 0; k < 5; k++) begin
      @(posedge MCLK iff SAMPLE_VALID === 1'b1);
      si = SAMPLE_Q;
      #1 chk(DEMOD_I, si);
      chk(OFFSET_INDEX, 4'he - idx);
      chk(OFFSET_SHIFT, idx == 4'h0 ? 4'h9 : 4'h7);
      idx = 4'he - idx;
    end
    wr(ADDR_CTRL_A, 32'h7fff0044);
    @(posedge MCLK iff SAMPLE_VALID === 1'b1);
    si = SAMPLE_I;
    slow <= 1'b0;
    #1 chk(DEMOD_I, si);
    chk(OFFSET_VALID, 1'b1);
  endtask
  task automatic t_rssi;
    rs(6'h3e, 8'h42, 8'h40, 1'b0);
    rs(6'h3e, 8'h43, 8'h41, 1'b1);
    rs(6'h1f, 8'h7f, 8'h7f, 1'b1);
    rs(6'h20, 8'h05, 8'h00, 1'b0);
    rs(6'h1f, 8'h11, 8'h30, 1'b0);
    @(posedge MCLK);
    BB_MAG <= 4'hc;
    wr(ADDR_CTRL_A, 32'h7fff0064);
    AGC_FROZEN <= 1'b1;
    BB_MAG <= 4'h3;
    pulse(3'h4);
    rd(ADDR_STATUS, 32'h000c1730);
    chk(ANTENNA, 1'b1);
    wr(ADDR_CTRL_A, 32'h7fff0074);
    rd(ADDR_CTRL_A, 32'h7fff0074);
    chk(ANTENNA, 1'b0);
    AUTO_ANTENNA <= 1'b1;
    repeat (2) @(posedge MCLK);
    #1 chk(ANTENNA, 1'b1);
  endtask
  task automatic t_detect;
    wr(ADDR_CTRL_A, 32'h7fff0044);
    oks(2);
    sym(16'd150, 6'd10, 4'h7, 1'b0);
    oks(1);
    sym(16'd151, 6'd10, 4'h7, 1'b1);
    for (int k = 1; k <= 8; k++) sym(16'd151, 6'd10, 4'h7, k < 8);
    wr(ADDR_CTRL_A, 32'h7fff004c);
    oks(2);
    sym(16'd150, 6'd10, 4'h7, 1'b0);
    oks(3);
    sym(16'd151, 6'd10, 4'h7, 1'b1);
    wr(ADDR_CTRL_B, 32'h08010301);
    sym(16'd151, 6'd10, 4'h7, 1'b0);
    oks(1);
    sym(16'd151, 6'd14, 4'h7, 1'b0);
    oks(3);
    sym(16'd151, 6'd10, 4'h7, 1'b1);
    sym(16'd151, 6'd10, 4'h7, 1'b0);
    oks(1);
    sym(16'd151, 6'd10, 4'h9, 1'b0);
    oks(3);
    sym(16'd151, 6'd10, 4'h8, 1'b1);
    pulse(3'h1);
    sym(16'd151, 6'd10, 4'h7, 1'b1);
    pulse(3'h2);
    @(posedge MCLK);
    #1 chk(PREAMBLE_DETECTED, 1'b0);
    rd(ADDR_STATUS, 32'h000c0830);
  endtask
  task automatic t_peak;
    @(posedge MCLK);
    CORR_VALID <= 1'b1;
    CORR_PEAK <= 16'd300;
    CORR_TIME <= 6'd20;
    CORR_FREQ <= 4'h3;
    @(posedge MCLK);
    CORR_PEAK <= 16'd200;
    CORR_TIME <= 6'd30;
    CORR_FREQ <= 4'h5;
    SYMBOL_END <= 1'b1;
    @(posedge MCLK);
    CORR_VALID <= 1'b0;
    SYMBOL_END <= 1'b0;
    #1 chk({SYM_INDEX_VALID, SYM_FREQ_INDEX, SYM_TIME_INDEX}, {1'b1, 4'h3, 6'd20});
  endtask
  task automatic t_reset;
    @(posedge MCLK);
    RESET <= 1'b1;
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    rd(ADDR_CTRL_A, CTRL_A_RESET);
    rd(ADDR_CTRL_B, CTRL_B_RESET);
    rd(ADDR_STATUS, 32'h0);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge MCLK);
    RESET <= 1'b0;
    t_regs();
    t_stream();
    t_rssi();
    t_detect();
    t_peak();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
